/* core/stpwm_timer.sv */
// Ten-bit standard timer with compare and PWM output, APB slave
//
// Summary of operation
// - Compare mode: control bit sets initial level
// - PWM mode: control bit picks active level
// - Single pulse: control bit sets start level
// - Invert bit flips pin; unused in timer
// - Clear select: A match or P/overflow
// - Overflow always clears; P matches only when period field nonzero
// - Counter readable as two read-only bytes
// - Compare A held in two RW bytes
// - Mode 00 is compare-match output mode
// - Mode 11 timer: same, pin undriven
// - PWM needs mode 10 and function 10
// - Clear select 0: both flags raised
// - Clear select 1: only A flag
// - Compare A zero never matches outside PWM mode
// - Compare mode pin changes only on A match or counter-on rise
// - Function 00 leaves pin unchanged
// - Counter-on rise reloads initial pin level
// - PWM mode raises both match flags, except P in single pulse
// - PWM function forces levels or passes wave
// - Swap 0: period field, duty compare A
// - Duty at or above period: full active
// - Swap 1: period compare A, duty field
// - On rise clears counter, fall holds
// - Comparator P checks counter bits 9..7
// - Compare functions: none, low, high, toggle
// - PWM functions: inactive, active, wave, pulse
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "stpwm_regs.svh"

module stpwm_timer
  import stpwm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        count_tick,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             timer_out,
  output logic             timer_out_en_n,
  output logic             match_a_flag,
  output logic             match_p_flag
);

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [10:0] field_span(input logic [2:0] f);
    field_span = (f == 3'b000) ? `STPWM_PER_FULL
                               : {1'b0, f, 7'h00};
  endfunction : field_span

  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  function automatic logic [31:0] read_word(input logic [11:0]  a,
                                            input stpwm_state_t s);
    read_word = 32'h0000_0000;
    case (a)
      `STPWM_OFF_CTRL0:   read_word = {28'h0, s.ctrl0};
      `STPWM_OFF_CTRL1:   read_word = {24'h0, s.ctrl1};
      `STPWM_OFF_CNT_LO:  read_word = {24'h0, s.count[7:0]};
      `STPWM_OFF_CNT_HI:  read_word = {30'h0, s.count[9:8]};
      `STPWM_OFF_CMPA_LO: read_word = {24'h0, s.compare_a_value[7:0]};
      `STPWM_OFF_CMPA_HI: read_word = {30'h0, s.compare_a_value[9:8]};
      default:            read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  stpwm_state_t st_r;
  stpwm_state_t st_nxt;

  logic        on_bit;
  logic [2:0]  period_field;
  stpwm_mode_t mode;
  logic        on_rise;
  logic        access;
  logic        wr;
  logic        mapped;
  logic        match_a;
  logic        match_p;
  logic        overflow;
  logic        clear_cnt;
  logic [10:0] pwm_period;
  logic [10:0] pwm_duty;
  logic        pwm_active;
  logic        wave;

  assign on_bit       = st_r.ctrl0[`STPWM_CTRL0_ON_BIT];
  assign period_field = st_r.ctrl0[2:0];
  assign mode         = stpwm_mode_t'(st_r.ctrl1.mode_sel);
  assign on_rise      = on_bit & ~st_r.on_prev;
  assign access       = psel & penable;
  assign wr           = access & pwrite;

  assign mapped = addr_hit(paddr, `STPWM_OFF_CTRL0)
                | addr_hit(paddr, `STPWM_OFF_CTRL1)
                | addr_hit(paddr, `STPWM_OFF_CNT_LO)
                | addr_hit(paddr, `STPWM_OFF_CNT_HI)
                | addr_hit(paddr, `STPWM_OFF_CMPA_LO)
                | addr_hit(paddr, `STPWM_OFF_CMPA_HI);

  // --------------------------------------------------------------
  // Comparators
  // --------------------------------------------------------------
  always_comb
  begin
    match_a  = 1'b0;
    match_p  = 1'b0;
    overflow = 1'b0;
    if (on_bit && count_tick)
    begin
      // Zero compare value never matches in compare mode
      match_a = (st_r.count == st_r.compare_a_value - 10'h001)
              && (st_r.compare_a_value != 10'h000
                  || mode == STPWM_MODE_PWM);
      // Period field zero is the 1024 case, i.e. overflow
      // Last count before bits 9..7 reach the field: a 128 multiple
      match_p = (period_field != 3'b000)
              && (st_r.count == {period_field - 3'b001, 7'h7F});
      overflow = (st_r.count == `STPWM_CNT_MAX);
    end
  end

  // PWM period and duty sources
  always_comb
  begin
    if (st_r.ctrl1.period_duty_swap)
    begin
      pwm_period = (st_r.compare_a_value == 10'h000)
                 ? `STPWM_PER_FULL
                 : {1'b0, st_r.compare_a_value};
      pwm_duty   = field_span(period_field);
    end
    else
    begin
      pwm_period = field_span(period_field);
      pwm_duty   = {1'b0, st_r.compare_a_value};
    end
    // Duty at or beyond period keeps the wave active all period
    pwm_active = ({1'b0, st_r.count} < pwm_duty)
              || (pwm_duty >= pwm_period);
    wave = st_r.ctrl1.output_level_select ? pwm_active
                                          : ~pwm_active;
  end

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.on_prev = on_bit;
    clear_cnt      = 1'b0;
    st_nxt.match_a_flag = 1'b0;
    st_nxt.match_p_flag = 1'b0;

    // Counter: cleared on start, held while off
    if (on_rise)
    begin
      st_nxt.count = `STPWM_CNT_RESET;
    end
    else if (on_bit && count_tick)
    begin
      case (mode)
        STPWM_MODE_CMP, STPWM_MODE_TMR:
        begin
          if (st_r.ctrl1.clear_source_select)
            clear_cnt = match_a | overflow;
          else
            clear_cnt = match_p | overflow;
          st_nxt.match_a_flag = match_a;
          st_nxt.match_p_flag = match_p
                 & ~st_r.ctrl1.clear_source_select;
        end
        STPWM_MODE_PWM:
        begin
          if (st_r.ctrl1.pin_function == 2'b11)
            clear_cnt = overflow;
          else
            clear_cnt = ({1'b0, st_r.count} == pwm_period - 11'h001);
          st_nxt.match_a_flag = match_a;
          st_nxt.match_p_flag = match_p
                 & (st_r.ctrl1.pin_function != 2'b11);
        end
        default:
        begin
          clear_cnt = match_p | overflow;
          st_nxt.match_p_flag = match_p;
        end
      endcase
      st_nxt.count = clear_cnt ? `STPWM_CNT_RESET
                               : st_r.count + 10'h001;
    end

    // Output pin level before inversion
    if (on_rise)
    begin
      st_nxt.pin_level = st_r.ctrl1.output_level_select;
    end
    else if (mode == STPWM_MODE_CMP && match_a)
    begin
      case (st_r.ctrl1.pin_function)
        2'b00:   st_nxt.pin_level = st_r.pin_level;
        2'b01:   st_nxt.pin_level = 1'b0;
        2'b10:   st_nxt.pin_level = 1'b1;
        default: st_nxt.pin_level = ~st_r.pin_level;
      endcase
    end
    else if (mode == STPWM_MODE_PWM
             && st_r.ctrl1.pin_function == 2'b11 && match_a)
    begin
      // Single pulse ends on compare A and stops the counter
      st_nxt.pin_level = ~st_r.ctrl1.output_level_select;
      st_nxt.ctrl0[`STPWM_CTRL0_ON_BIT] = 1'b0;
    end
    else if (mode == STPWM_MODE_PWM
             && st_r.ctrl1.pin_function == 2'b11 && !on_bit)
    begin
      st_nxt.pin_level = ~st_r.ctrl1.output_level_select;
    end

    // Register writes; software write wins over hardware stop
    if (wr && addr_hit(paddr, `STPWM_OFF_CTRL0))
      st_nxt.ctrl0 = pwdata[3:0] & `STPWM_CTRL0_MASK;
    if (wr && addr_hit(paddr, `STPWM_OFF_CTRL1))
      st_nxt.ctrl1 = stpwm_ctrl1_t'(pwdata[7:0]);
    if (wr && addr_hit(paddr, `STPWM_OFF_CMPA_LO))
      st_nxt.compare_a_value[7:0] = pwdata[7:0];
    if (wr && addr_hit(paddr, `STPWM_OFF_CMPA_HI))
      st_nxt.compare_a_value[9:8] = pwdata[1:0];

    // Read word snapped at the setup edge so prdata comes from a flop
    st_nxt.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
      st_nxt.rdata = read_word(paddr, st_r);
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else if (clk_en)
      st_r <= st_nxt;
  end

  // --------------------------------------------------------------
  // APB answer and outputs
  // --------------------------------------------------------------
  // Zero wait states; a counter read shows the value at the setup edge
  assign prdata  = st_r.rdata;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Final pin level; PWM logic keeps running under forced levels
  always_comb
  begin
    logic lvl;
    lvl = st_r.pin_level;
    if (mode == STPWM_MODE_PWM)
    begin
      case (st_r.ctrl1.pin_function)
        2'b00:   lvl = ~st_r.ctrl1.output_level_select;
        2'b01:   lvl = st_r.ctrl1.output_level_select;
        2'b10:   lvl = on_bit ? wave
                              : ~st_r.ctrl1.output_level_select;
        default: lvl = st_r.pin_level;
      endcase
    end
    timer_out = (mode == STPWM_MODE_TMR || mode == STPWM_MODE_CAP)
              ? 1'b0
              : lvl ^ st_r.ctrl1.output_invert;
  end

  // Pin released in timer and capture modes
  assign timer_out_en_n = (mode == STPWM_MODE_TMR)
                        | (mode == STPWM_MODE_CAP);
  assign match_a_flag   = st_r.match_a_flag;
  assign match_p_flag   = st_r.match_p_flag;

endmodule : stpwm_timer
`default_nettype wire

/* inc/stpwm_regs.svh */
// Register offsets, field positions and reset values of the standard timer
`ifndef STPWM_REGS_SVH
`define STPWM_REGS_SVH

`define STPWM_OFF_CTRL0      12'h000
`define STPWM_OFF_CTRL1      12'h004
`define STPWM_OFF_CNT_LO     12'h008
`define STPWM_OFF_CNT_HI     12'h00C
`define STPWM_OFF_CMPA_LO    12'h010
`define STPWM_OFF_CMPA_HI    12'h014

`define STPWM_CTRL0_ON_BIT   3
`define STPWM_CTRL0_MASK     4'hF
`define STPWM_CTRL_RESET     8'h00
`define STPWM_CNT_RESET      10'h000
`define STPWM_CNT_MAX        10'h3FF
`define STPWM_PER_UNIT       11'h080
`define STPWM_PER_FULL       11'h400

`endif

/* inc/stpwm_pkg.sv */
// Types shared by the standard timer design
package stpwm_pkg;

  typedef enum logic [1:0] {
    STPWM_MODE_CMP  = 2'b00,
    STPWM_MODE_CAP  = 2'b01,
    STPWM_MODE_PWM  = 2'b10,
    STPWM_MODE_TMR  = 2'b11
  } stpwm_mode_t;

  typedef struct packed {
    logic [1:0] mode_sel;
    logic [1:0] pin_function;
    logic       output_level_select;
    logic       output_invert;
    logic       period_duty_swap;
    logic       clear_source_select;
  } stpwm_ctrl1_t;

  typedef enum {
    STPWM_IDLE,
    STPWM_RUN
  } stpwm_run_t;

  typedef struct packed {
    logic [3:0]   ctrl0;
    stpwm_ctrl1_t ctrl1;
    logic [9:0]   count;
    logic [9:0]   compare_a_value;
    logic         on_prev;
    logic         pin_level;
    logic         match_a_flag;
    logic         match_p_flag;
    logic [31:0]  rdata;
  } stpwm_state_t;

endpackage : stpwm_pkg

/* testbench/stpwm_timer_assertions.sv */
// Port-level checker for the standard timer
`timescale 1ns/100ps
`default_nettype none
module stpwm_timer_assertions
  import stpwm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        count_tick,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_out,
  input wire logic        timer_out_en_n,
  input wire logic        match_a_flag,
  input wire logic        match_p_flag
);
  // ------------------------------------------------------------
  // Shadow of control bits, rebuilt from bus writes
  // ------------------------------------------------------------
  logic [7:0] ctrl1_r;
  logic       on_r;
  logic       wr;
  logic [1:0] md;
  assign wr = psel && penable && pwrite && pready && clk_en;
  assign md = ctrl1_r[7:6];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl1_r <= 8'h00;
      on_r    <= 1'b0;
    end
    else
    begin
      if (wr && paddr == 12'h004)
        ctrl1_r <= pwdata[7:0];
      if (wr && paddr == 12'h000)
        on_r <= pwdata[3];
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence on_rise_s;
    $rose(on_r) && md == 2'b00;
  endsequence
  AST_FLAG_A_TICK: assert property (
    match_a_flag && $past(clk_en) |-> $past(count_tick))
    else $error("match a without tick");
  AST_FLAG_P_TICK: assert property (
    match_p_flag && $past(clk_en) |-> $past(count_tick))
    else $error("match p without tick");
  AST_PIN_RELEASE: assert property (
    timer_out_en_n == md[0])
    else $error("pin enable wrong for mode");
  AST_TMR_PIN_LOW: assert property (
    md == 2'b11 |-> !timer_out)
    else $error("pin driven in timer mode");
  AST_PWM_FORCED: assert property (
    md == 2'b10 && !ctrl1_r[5]
    |-> timer_out == ((ctrl1_r[4] ~^ ctrl1_r[3]) ^ ctrl1_r[2]))
    else $error("forced pwm level wrong");
  AST_NO_P_FLAG: assert property (
    md[0] == md[1] && ctrl1_r[0] && $stable(ctrl1_r) |-> !match_p_flag)
    else $error("p flag with clear on a");
  AST_UNMAPPED: assert property (
    psel && penable && (paddr > 12'h014 || paddr[1:0] != 2'b00)
    |-> pslverr)
    else $error("no error on unmapped");
  AST_HI_BYTES: assert property (
    psel && !pwrite && (paddr == 12'h00C || paddr == 12'h014)
    |-> prdata[31:2] == 30'h0)
    else $error("high byte upper bits set");
  AST_RISE_RELOAD: assert property (
    on_rise_s |=> timer_out == (ctrl1_r[3] ^ ctrl1_r[2]))
    else $error("pin not reloaded");
endmodule : stpwm_timer_assertions
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the standard timer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import stpwm_pkg::*;
  logic        pclk, presetn, clk_en, count_tick, psel, penable, pwrite;
  logic        pready, pslverr, timer_out, timer_out_en_n, er;
  logic        match_a_flag, match_p_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  int          errors, n_compared, na, np, nh;
  stpwm_timer i_dut (.pclk, .presetn, .clk_en, .count_tick, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .timer_out, .timer_out_en_n, .match_a_flag, .match_p_flag);
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task print_verdict;
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // --------------------------------------------------------------
  // Bus cycle and run helpers
  // --------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Counter off first: mode changes while running are unsafe
  task setup(input logic [7:0] c1, input logic [9:0] ca,
             input logic [3:0] c0);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, {24'h0, c1});
    apb(1'b1, 12'h010, {24'h0, ca[7:0]});
    apb(1'b1, 12'h014, {30'h0, ca[9:8]});
    apb(1'b1, 12'h000, {28'h0, c0});
  endtask : setup
  task run(input int n);
    na = 0;
    np = 0;
    nh = 0;
    repeat (n)
    begin
      @(posedge pclk);
      na += match_a_flag;
      np += match_p_flag;
      nh += timer_out;
    end
  endtask : run
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task test_regs;
    for (int k = 0; k < 24; k += 4)
    begin
      apb(1'b0, k[11:0], 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b1, 12'h010, 32'hFFFFFFAB);
    apb(1'b1, 12'h014, 32'hFFFFFFFF);
    apb(1'b1, 12'h008, 32'h55);
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'hAB);
    apb(1'b0, 12'h014, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    check({31'h0, er}, 32'h1);
    // Reset in mid-run must clear the written compare value
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    check(rd, 32'h0);
  endtask : test_regs
  task test_cmp;
    // Control value and expected pin after three A matches
    logic [11:0] t [6] = '{12'h081, 12'h180, 12'h201, 12'h380,
                           12'h3C1, 12'hF80};
    foreach (t[k])
    begin
      setup(t[k][11:4], 10'h020, 4'h9);
      run(2);
      check(timer_out, (t[k][7] ^ t[k][6]) & ~t[k][10]);
      check(timer_out_en_n, t[k][10]);
      run(300);
      check(na, 3);
      check(np, 2);
      check(timer_out, t[k][0]);
    end
    setup(8'h39, 10'h040, 4'h9);
    run(300);
    check(np, 0);
    check(na, 4);
    setup(8'h38, 10'h000, 4'h8);
    run(1100);
    check(na, 0);
    setup(8'h38, 10'h200, 4'h8);
    run(1100);
    check(na, 1);
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    v = rd;
    run(5);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, v);
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b0, 12'h008, 32'h0);
    check(rd < 8, 1);
  endtask : test_cmp
  task test_pwm;
    // Control, A flags per 256, compare A value, high cycles per 256
    logic [31:0] t [6] = '{32'hA8820040, 32'hAC8200C0, 32'hA8200100,
                           32'hAA500080, 32'h88820000, 32'h98820100};
    foreach (t[k])
    begin
      setup(t[k][31:24], t[k][21:12], 4'h9);
      run(8);
      run(256);
      check(nh, t[k][11:0]);
      check(na, t[k][23:22]);
      check(np, 2 - t[k][25]);
    end
  endtask : test_pwm
  task test_pulse_enables;
    // Single pulse: active for the compare A span, then self-stop
    setup(8'hB8, 10'h040, 4'h8);
    run(1);
    run(100);
    check(nh, 32'h40);
    check(na, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    // Capture mode: pin released, counter free-running
    setup(8'h48, 10'h000, 4'h8);
    run(10);
    check(timer_out_en_n, 1'b1);
    check(timer_out, 1'b0);
    // Tick low, then clock enable low: count frozen for 20 cycles
    for (int j = 0; j < 2; j++)
    begin
      apb(1'b0, 12'h008, 32'h0);
      v = rd;
      if (j == 0)
        count_tick <= 1'b0;
      else
        clk_en <= 1'b0;
      run(20);
      count_tick <= 1'b1;
      clk_en     <= 1'b1;
      apb(1'b0, 12'h008, 32'h0);
      check(rd, {24'h0, 8'(v[7:0] + 8'h03)});
    end
  endtask : test_pulse_enables
  initial
  begin
    presetn = 1'b0;
    clk_en = 1'b1;
    count_tick = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    errors = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_regs;
    test_cmp;
    test_pwm;
    test_pulse_enables;
    print_verdict;
  end
  initial
  begin
    repeat (40000) @(posedge pclk);
    errors++;
    print_verdict;
  end
endmodule : tb_top
bind stpwm_timer stpwm_timer_assertions i_chk (.pclk, .presetn, .clk_en,
  .count_tick, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .timer_out, .timer_out_en_n, .match_a_flag,
  .match_p_flag);
`default_nettype wire
